// ==== pcie_capability_fields.sv ====
// capability field bank: root, slot, msi-x placement and power management
// assumes link-side accesses are already decoded to a dword index on CLK,
// and that user management writes arrive on the same clock
`timescale 1ns/100ps

// What this block does
// R1: crs returned to software when visible
// R2: slot fields only for root port slots
// R3: one presence flag per slot item
// R4: surprise flag advertises unannounced adapter removal
// R5: hot-plug capable flag only advertises
// R6: user writes presence detect via management
// R7: no command notification when flag set
// R8: power limit is value with scale
// R9: physical slot number fixed at build
// R10: msi-x present only with memory bar
// R11: table bar names lower dword of pair
// R12: pending array placed by own bar
// R13: device specific init flag advertised
// R14: separate d1 and d2 support flags
// R15: wake only in listed power states
// R16: d3hot to d0 keeps configuration context
// R17: no soft reset always reads set
// R18: power budget always reads zero
// R19: power dissipation always reads zero
// R20: fixed fields ignore link writes
module pcie_capability_fields #(
  parameter bit PORT_IS_ROOT = 1'b1,
  parameter bit SLOT_IMPLEMENTED = 1'b0,
  parameter bit CRS_SW_VIS = 1'b0,
  parameter bit ATTN_BUTTON = 1'b0,
  parameter bit ATTN_IND = 1'b0,
  parameter bit PWR_CTRL = 1'b0,
  parameter bit PWR_IND = 1'b0,
  parameter bit HP_SURPRISE = 1'b0,
  parameter bit HP_CAPABLE = 1'b0,
  parameter bit MRL_SENSOR = 1'b0,
  parameter bit EM_INTERLOCK = 1'b0,
  parameter bit NO_CMD_CPL = 1'b0,
  parameter logic [7:0] SLOT_PWR_VALUE = 8'h00,
  parameter logic [1:0] SLOT_PWR_SCALE = 2'h0,
  parameter logic [12:0] PHYS_SLOT_NUM = 13'h0000,
  parameter bit MSIX_ENABLE = 1'b0,
  parameter logic [5:0] MEM_BAR_MASK = 6'h01,
  parameter logic [5:0] BAR64_UPPER_MASK = 6'h00,
  parameter logic [28:0] MSIX_TBL_OFFSET = 29'h0000_0000,
  parameter logic [2:0] MSIX_TBL_BIR = 3'h0,
  parameter logic [28:0] MSIX_PBA_OFFSET = 29'h0000_0000,
  parameter logic [2:0] MSIX_PBA_BIR = 3'h0,
  parameter bit DEV_SPEC_INIT = 1'b0,
  parameter bit D1_SUPPORT = 1'b0,
  parameter bit D2_SUPPORT = 1'b0,
  parameter logic [4:0] PME_SUPPORT = 5'h00
) (
  input wire logic CLK,
  input wire logic ARST_N,
  input wire logic CE,
  input wire pcie_cap_pkg::cfg_req_s CFG_REQ,
  output pcie_cap_pkg::cfg_rsp_s CFG_RSP,
  input wire logic MGMT_PRESENCE_WR,
  input wire logic MGMT_PRESENCE,
  input wire logic HP_CMD_DONE,
  output logic HP_CMD_NOTIFY,
  input wire logic CPL_CRS,
  output logic CRS_TO_SW,
  output logic CRS_RETRY,
  input wire logic USER_WAKE,
  output logic PM_WAKE_REQUEST,
  output logic [1:0] PM_STATE,
  output logic MSIX_PRESENT,
  output logic SLOT_ENABLED
);

  // a bir naming the upper half of a 64-bit pair folds to the lower one
  function automatic logic [2:0] fold_bir(input logic [2:0] bir);
    if (bir != 3'h0 && bir < 3'h6 && BAR64_UPPER_MASK[bir]) begin
      fold_bir = bir - 3'h1;
    end else begin
      fold_bir = bir;
    end
  endfunction

  // placement dword: offset above, bar indicator in the low three bits
  function automatic logic [31:0] place(input logic [28:0] off,
                                        input logic [2:0] bir,
                                        input logic present);
    place = present ? {off, fold_bir(bir)} : pcie_cap_pkg::RST_DWORD;
  endfunction

  // a slot flag shows only when the slot fields are selectable
  function automatic logic slot_bit(input logic want, input logic en);
    slot_bit = want & en;
  endfunction

  logic rst_n;
  logic slot_en;
  logic msix_en;
  pcie_cap_pkg::slot_cap_s slot_cap;
  logic [31:0] pm_cap;
  logic [31:0] root_dword;
  logic [31:0] slot_ctl_dword;
  logic [31:0] csr_dword;
  logic [31:0] read_mux;

  // link- and management-writable state
  logic crs_en;
  logic [pcie_cap_pkg::SLOT_CTL_WIDTH-1:0] slot_ctl;
  logic cmd_done;
  logic presence;
  logic pme_en;
  logic pme_stat;
  logic [3:0] dsel;

  logic next_crs_en;
  logic [pcie_cap_pkg::SLOT_CTL_WIDTH-1:0] next_slot_ctl;
  logic next_cmd_done;
  logic next_presence;
  logic next_pme_en;
  logic next_pme_stat;
  logic [3:0] next_dsel;

  // output staging
  pcie_cap_pkg::cfg_rsp_s next_rsp;
  logic next_notify;
  logic next_crs_sw;
  logic next_crs_retry;

  logic wr_root;
  logic wr_slot;
  logic wr_csr;

  logic [1:0] pm_field;
  logic pm_wake;

  reset_sync u_reset_sync (
    .clk(CLK),
    .arst_n(ARST_N),
    .rst_n(rst_n)
  );

  // build-time gates
  assign slot_en = PORT_IS_ROOT & SLOT_IMPLEMENTED; // R2
  assign msix_en = MSIX_ENABLE & (|MEM_BAR_MASK); // R10

  // slot capabilities; each item flag set only if that item exists
  assign slot_cap.attn_button = slot_bit(ATTN_BUTTON, slot_en); // R3
  assign slot_cap.attn_ind = slot_bit(ATTN_IND, slot_en); // R3
  assign slot_cap.pwr_ctrl = slot_bit(PWR_CTRL, slot_en); // R3
  assign slot_cap.pwr_ind = slot_bit(PWR_IND, slot_en); // R3
  assign slot_cap.mrl_sensor = slot_bit(MRL_SENSOR, slot_en); // R3
  assign slot_cap.em_interlock = slot_bit(EM_INTERLOCK, slot_en); // R3
  assign slot_cap.hp_surprise = slot_bit(HP_SURPRISE, slot_en); // R4

  // advertised only: nothing in this bank reacts to hot-plug capability
  assign slot_cap.hp_capable = slot_bit(HP_CAPABLE, slot_en); // R5
  assign slot_cap.no_cmd_cpl = slot_bit(NO_CMD_CPL, slot_en); // R7

  // limit in watts is value times the scale step; both read together
  assign slot_cap.pwr_value = slot_en ? SLOT_PWR_VALUE : 8'h00; // R8
  assign slot_cap.pwr_scale = slot_en ? SLOT_PWR_SCALE : 2'h0; // R8

  // hardware-initialised, never writable
  assign slot_cap.phys_slot = slot_en ? PHYS_SLOT_NUM : 13'h0000; // R9

  // power management capability dword
  assign pm_cap = {PME_SUPPORT, // R15
                   D2_SUPPORT, // R14
                   D1_SUPPORT, // R14
                   3'h0,
                   DEV_SPEC_INIT, // R13
                   1'b0,
                   1'b0,
                   pcie_cap_pkg::PM_VERSION,
                   pcie_cap_pkg::PM_NEXT_PTR,
                   pcie_cap_pkg::PM_CAP_ID};

  // root capabilities with the software visibility enable above it
  always_comb begin
    root_dword = pcie_cap_pkg::RST_DWORD;
    root_dword[pcie_cap_pkg::ROOT_CRS_VIS_BIT] = CRS_SW_VIS & PORT_IS_ROOT; // R1
    root_dword[pcie_cap_pkg::ROOT_CRS_EN_BIT] = crs_en;
  end

  // slot control low half, slot status high half
  always_comb begin
    slot_ctl_dword = pcie_cap_pkg::RST_DWORD;
    slot_ctl_dword[pcie_cap_pkg::SLOT_CTL_WIDTH-1:0] = slot_ctl;
    slot_ctl_dword[pcie_cap_pkg::SLOT_CMD_DONE_BIT] = cmd_done;
    slot_ctl_dword[pcie_cap_pkg::SLOT_PRESENCE_BIT] = presence; // R6
  end

  // control/status; data and scale fields stay zero for every select
  always_comb begin
    csr_dword = pcie_cap_pkg::RST_DWORD; // R19
    csr_dword[pcie_cap_pkg::CSR_STATE_LSB +: 2] = pm_field;
    csr_dword[pcie_cap_pkg::CSR_NSR_BIT] = 1'b1; // R17
    csr_dword[pcie_cap_pkg::CSR_PME_EN_BIT] = pme_en;
    csr_dword[pcie_cap_pkg::CSR_DSEL_LSB +: 4] = dsel;
    csr_dword[pcie_cap_pkg::CSR_PME_STAT_BIT] = pme_stat;
  end

  // read selection; fixed fields come straight from build values
  always_comb begin
    case (CFG_REQ.idx)
      pcie_cap_pkg::IDX_ROOT: read_mux = root_dword;
      pcie_cap_pkg::IDX_SLOT_CAP: read_mux = slot_cap; // R20
      pcie_cap_pkg::IDX_SLOT_CTL: read_mux = slot_ctl_dword;
      pcie_cap_pkg::IDX_MSIX_TBL:
        read_mux = place(MSIX_TBL_OFFSET, MSIX_TBL_BIR, msix_en); // R11
      pcie_cap_pkg::IDX_MSIX_PBA:
        read_mux = place(MSIX_PBA_OFFSET, MSIX_PBA_BIR, msix_en); // R12
      pcie_cap_pkg::IDX_PM_CAP: read_mux = pm_cap; // R20
      pcie_cap_pkg::IDX_PM_CSR: read_mux = csr_dword;
      pcie_cap_pkg::IDX_PWR_DATA: read_mux = pcie_cap_pkg::RST_DWORD; // R18
      default: read_mux = pcie_cap_pkg::RST_DWORD;
    endcase
  end

  // write strobes per writable dword; any other index is dropped
  assign wr_root = CFG_REQ.wr & (CFG_REQ.idx == pcie_cap_pkg::IDX_ROOT); // R20
  assign wr_slot = CFG_REQ.wr & (CFG_REQ.idx == pcie_cap_pkg::IDX_SLOT_CTL);
  assign wr_csr = CFG_REQ.wr & (CFG_REQ.idx == pcie_cap_pkg::IDX_PM_CSR);

  pm_tracker u_pm_tracker (
    .clk(CLK),
    .rst_n(rst_n),
    .ce(CE),
    .wr_state(wr_csr),
    .new_field(CFG_REQ.data[pcie_cap_pkg::CSR_STATE_LSB +: 2]),
    .d1_ok(D1_SUPPORT),
    .d2_ok(D2_SUPPORT),
    .pme_support(PME_SUPPORT),
    .pme_en(pme_en),
    .wake_in(USER_WAKE),
    .state_field(pm_field),
    .wake_out(pm_wake)
  );

  // next values of link and management writable state
  always_comb begin
    next_crs_en = crs_en;
    next_slot_ctl = slot_ctl;
    next_cmd_done = cmd_done;
    next_presence = presence;
    next_pme_en = pme_en;
    next_pme_stat = pme_stat;
    next_dsel = dsel;

    // visibility enable sticks wherever CRS_SW_VIS is set, root port or not
    if (wr_root) begin
      next_crs_en = CFG_REQ.data[pcie_cap_pkg::ROOT_CRS_EN_BIT] & CRS_SW_VIS; // R1
    end

    // slot control only exists for a root port with a slot
    if (wr_slot && slot_en) begin // R2
      next_slot_ctl = CFG_REQ.data[pcie_cap_pkg::SLOT_CTL_WIDTH-1:0];
    end

    // write-one-to-clear status; a same-cycle set wins
    if (wr_slot && CFG_REQ.data[pcie_cap_pkg::SLOT_CMD_DONE_BIT]) begin
      next_cmd_done = 1'b0;
    end
    if (HP_CMD_DONE && slot_en && !NO_CMD_CPL) begin // R7
      next_cmd_done = 1'b1;
    end

    // presence comes only from the user side, never from the link
    if (MGMT_PRESENCE_WR && slot_en) begin // R6
      next_presence = MGMT_PRESENCE;
    end

    // power state change leaves every other context bit untouched
    if (wr_csr) begin // R16
      next_pme_en = CFG_REQ.data[pcie_cap_pkg::CSR_PME_EN_BIT];
      next_dsel = CFG_REQ.data[pcie_cap_pkg::CSR_DSEL_LSB +: 4];
      if (CFG_REQ.data[pcie_cap_pkg::CSR_PME_STAT_BIT]) begin
        next_pme_stat = 1'b0;
      end
    end
    if (pm_wake) begin // R15
      next_pme_stat = 1'b1;
    end
  end

  // registered answers and event pulses
  always_comb begin
    next_rsp.valid = CFG_REQ.rd;
    next_rsp.data = CFG_REQ.rd ? read_mux : pcie_cap_pkg::RST_DWORD;
    next_notify = HP_CMD_DONE & slot_en & ~NO_CMD_CPL &
                  slot_ctl[pcie_cap_pkg::SLOT_CC_IE_BIT]; // R7

    // crs goes to software only when visible; else the port reissues
    next_crs_sw = CPL_CRS & crs_en; // R1
    next_crs_retry = CPL_CRS & ~crs_en;
  end

  // context registers; reset only from the pin, never from a power change
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      crs_en <= pcie_cap_pkg::RST_BIT;
      slot_ctl <= '0;
      cmd_done <= pcie_cap_pkg::RST_BIT;
      presence <= pcie_cap_pkg::RST_BIT;
      pme_en <= pcie_cap_pkg::RST_BIT;
      pme_stat <= pcie_cap_pkg::RST_BIT;
      dsel <= 4'h0;
    end else if (CE) begin
      crs_en <= next_crs_en;
      slot_ctl <= next_slot_ctl;
      cmd_done <= next_cmd_done;
      presence <= next_presence;
      pme_en <= next_pme_en;
      pme_stat <= next_pme_stat;
      dsel <= next_dsel;
    end
  end

  // output flops, one cycle behind their causes; wake request and power state two, as pm_tracker registers them first
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      CFG_RSP <= '0;
      HP_CMD_NOTIFY <= pcie_cap_pkg::RST_BIT;
      CRS_TO_SW <= pcie_cap_pkg::RST_BIT;
      CRS_RETRY <= pcie_cap_pkg::RST_BIT;
      PM_WAKE_REQUEST <= pcie_cap_pkg::RST_BIT;
      PM_STATE <= pcie_cap_pkg::RST_PM_FIELD;
      MSIX_PRESENT <= pcie_cap_pkg::RST_BIT;
      SLOT_ENABLED <= pcie_cap_pkg::RST_BIT;
    end else if (CE) begin
      CFG_RSP <= next_rsp;
      HP_CMD_NOTIFY <= next_notify;
      CRS_TO_SW <= next_crs_sw;
      CRS_RETRY <= next_crs_retry;
      PM_WAKE_REQUEST <= pm_wake; // R15
      PM_STATE <= pm_field;
      MSIX_PRESENT <= msix_en; // R10
      SLOT_ENABLED <= slot_en; // R2
    end
  end

endmodule

// ==== pcie_cap_pkg.sv ====
// constants and carriers shared by the capability field bank
// assumes a 32-bit dword view of config space, indexed by a small dword number
package pcie_cap_pkg;

  // dword indices of the capability window
  localparam logic [2:0] IDX_ROOT = 3'h0;
  localparam logic [2:0] IDX_SLOT_CAP = 3'h1;
  localparam logic [2:0] IDX_SLOT_CTL = 3'h2;
  localparam logic [2:0] IDX_MSIX_TBL = 3'h3;
  localparam logic [2:0] IDX_MSIX_PBA = 3'h4;
  localparam logic [2:0] IDX_PM_CAP = 3'h5;
  localparam logic [2:0] IDX_PM_CSR = 3'h6;
  localparam logic [2:0] IDX_PWR_DATA = 3'h7;

  // field positions
  localparam int ROOT_CRS_VIS_BIT = 0;
  localparam int ROOT_CRS_EN_BIT = 16;
  localparam int SLOT_CC_IE_BIT = 4;
  localparam int SLOT_CTL_WIDTH = 13;
  localparam int SLOT_CMD_DONE_BIT = 20;
  localparam int SLOT_PRESENCE_BIT = 22;
  localparam int CSR_STATE_LSB = 0;
  localparam int CSR_NSR_BIT = 3;
  localparam int CSR_PME_EN_BIT = 8;
  localparam int CSR_DSEL_LSB = 9;
  localparam int CSR_PME_STAT_BIT = 15;

  // fixed values and values after reset
  localparam logic [7:0] PM_CAP_ID = 8'h01;
  localparam logic [7:0] PM_NEXT_PTR = 8'h00;
  localparam logic [2:0] PM_VERSION = 3'h3;
  localparam logic [31:0] RST_DWORD = 32'h0000_0000;
  localparam logic [1:0] RST_PM_FIELD = 2'h0;
  localparam logic RST_BIT = 1'b0;

  // power states, gray coded along D0..D3hot
  typedef enum logic [1:0] {
    PM_D0 = 2'b00,
    PM_D1 = 2'b01,
    PM_D2 = 2'b11,
    PM_D3HOT = 2'b10
  } pm_state_e;

  // one link-side configuration access
  typedef struct packed {
    logic rd;
    logic wr;
    logic [2:0] idx;
    logic [31:0] data;
  } cfg_req_s;

  // answer to a configuration read
  typedef struct packed {
    logic valid;
    logic [31:0] data;
  } cfg_rsp_s;

  // slot capabilities dword layout
  typedef struct packed {
    logic [12:0] phys_slot;
    logic no_cmd_cpl;
    logic em_interlock;
    logic [1:0] pwr_scale;
    logic [7:0] pwr_value;
    logic hp_capable;
    logic hp_surprise;
    logic pwr_ind;
    logic attn_ind;
    logic mrl_sensor;
    logic pwr_ctrl;
    logic attn_button;
  } slot_cap_s;

endpackage

// ==== reset_sync.sv ====
// reset release synchroniser for the field bank
// assumes the asynchronous reset may drop at any time relative to clk
`timescale 1ns/100ps
module reset_sync (
  input wire logic clk,
  input wire logic arst_n,
  output logic rst_n
);

  logic stage1;

  // assert at once, release two edges later; the bank clock enable does
  // not gate this so a frozen bank still leaves reset cleanly
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      stage1 <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      stage1 <= 1'b1;
      rst_n <= stage1;
    end
  end

endmodule

// ==== pm_tracker.sv ====
// power state holder with wake gating
// assumes state writes and wake requests arrive on the same clock
`timescale 1ns/100ps
module pm_tracker (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic wr_state,
  input wire logic [1:0] new_field,
  input wire logic d1_ok,
  input wire logic d2_ok,
  input wire logic [4:0] pme_support,
  input wire logic pme_en,
  input wire logic wake_in,
  output logic [1:0] state_field,
  output logic wake_out
);

  pcie_cap_pkg::pm_state_e state;
  pcie_cap_pkg::pm_state_e next_state;
  logic next_wake;

  // field code to gray state
  function automatic pcie_cap_pkg::pm_state_e to_state(input logic [1:0] f);
    case (f)
      2'h0: to_state = pcie_cap_pkg::PM_D0;
      2'h1: to_state = pcie_cap_pkg::PM_D1;
      2'h2: to_state = pcie_cap_pkg::PM_D2;
      default: to_state = pcie_cap_pkg::PM_D3HOT;
    endcase
  endfunction

  // next state: writes naming an unsupported state are dropped
  always_comb begin
    next_state = state;
    if (wr_state) begin
      case (to_state(new_field))
        pcie_cap_pkg::PM_D1: if (d1_ok) next_state = pcie_cap_pkg::PM_D1; // R14
        pcie_cap_pkg::PM_D2: if (d2_ok) next_state = pcie_cap_pkg::PM_D2; // R14
        default: next_state = to_state(new_field);
      endcase
    end
    // wake only from states listed in the support mask
    case (next_state)
      pcie_cap_pkg::PM_D0: next_wake = wake_in & pme_en & pme_support[0]; // R15
      pcie_cap_pkg::PM_D1: next_wake = wake_in & pme_en & pme_support[1]; // R15
      pcie_cap_pkg::PM_D2: next_wake = wake_in & pme_en & pme_support[2]; // R15
      default: next_wake = wake_in & pme_en & pme_support[3]; // R15
    endcase
  end

  // registers; state_field mirrors the field encoding
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= pcie_cap_pkg::PM_D0;
      state_field <= pcie_cap_pkg::RST_PM_FIELD;
      wake_out <= pcie_cap_pkg::RST_BIT;
    end else if (ce) begin
      state <= next_state;
      state_field <= (next_state == pcie_cap_pkg::PM_D0) ? 2'h0 :
                     (next_state == pcie_cap_pkg::PM_D1) ? 2'h1 :
                     (next_state == pcie_cap_pkg::PM_D2) ? 2'h2 : 2'h3;
      wake_out <= next_wake;
    end
  end

endmodule

// ==== pcie_capability_fields_asserts.sv ====
// assertion checker for the capability field bank
// assumes it is bound to the bank's top module and sees only its ports
`timescale 1ns/100ps
module pcie_capability_fields_asserts #(
  parameter bit PORT_IS_ROOT = 1'b1,
  parameter bit SLOT_IMPLEMENTED = 1'b0,
  parameter bit CRS_SW_VIS = 1'b0,
  parameter bit NO_CMD_CPL = 1'b0,
  parameter bit MSIX_ENABLE = 1'b0,
  parameter logic [5:0] MEM_BAR_MASK = 6'h01,
  parameter bit D1_SUPPORT = 1'b0,
  parameter bit D2_SUPPORT = 1'b0,
  parameter logic [4:0] PME_SUPPORT = 5'h00
) (
  input wire logic CLK,
  input wire logic ARST_N,
  input wire logic CE,
  input wire pcie_cap_pkg::cfg_req_s CFG_REQ,
  input wire pcie_cap_pkg::cfg_rsp_s CFG_RSP,
  input wire logic MGMT_PRESENCE_WR,
  input wire logic MGMT_PRESENCE,
  input wire logic HP_CMD_DONE,
  input wire logic HP_CMD_NOTIFY,
  input wire logic CPL_CRS,
  input wire logic CRS_TO_SW,
  input wire logic CRS_RETRY,
  input wire logic USER_WAKE,
  input wire logic PM_WAKE_REQUEST,
  input wire logic [1:0] PM_STATE,
  input wire logic MSIX_PRESENT,
  input wire logic SLOT_ENABLED
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!ARST_N);

  // a read taken on this edge
  logic rd_go;
  assign rd_go = CE && CFG_REQ.rd;

  // answers: one per taken read, quiet otherwise
  property p_rd_answer; rd_go |=> CFG_RSP.valid; endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
  property p_quiet; CE && !CFG_REQ.rd |=> CFG_RSP == '0; endproperty
  a_quiet: assert property (p_quiet) else $error("answer without a read");
  property p_pwr_zero; rd_go && CFG_REQ.idx == pcie_cap_pkg::IDX_PWR_DATA |=> CFG_RSP.data == '0;
  endproperty
  a_pwr_zero: assert property (p_pwr_zero) else $error("power data not zero");
  property p_nsr; rd_go && CFG_REQ.idx == pcie_cap_pkg::IDX_PM_CSR
    |=> CFG_RSP.data[pcie_cap_pkg::CSR_NSR_BIT]; endproperty
  a_nsr: assert property (p_nsr) else $error("no soft reset flag clear");

  // build-time presence levels settle within five edges of release
  property p_slot_en; ARST_N [*5] |-> SLOT_ENABLED == (PORT_IS_ROOT && SLOT_IMPLEMENTED);
  endproperty
  a_slot_en: assert property (p_slot_en) else $error("slot enable wrong");
  property p_msix; ARST_N [*5] |-> MSIX_PRESENT == (MSIX_ENABLE && (MEM_BAR_MASK != 6'h00));
  endproperty
  a_msix: assert property (p_msix) else $error("msix presence wrong");

  // crs completions go to exactly one place, software only when visible
  property p_crs; CE && CPL_CRS |=> (CRS_TO_SW != CRS_RETRY) && (!CRS_TO_SW || CRS_SW_VIS);
  endproperty
  a_crs: assert property (p_crs) else $error("crs routing wrong");
  property p_crs_cause; CRS_TO_SW || CRS_RETRY |-> $past(CE && CPL_CRS); endproperty
  a_crs_cause: assert property (p_crs_cause) else $error("crs output without cause");

  // notification only after a command, and never when suppressed
  property p_notify; HP_CMD_NOTIFY |-> $past(HP_CMD_DONE) && !NO_CMD_CPL && SLOT_ENABLED;
  endproperty
  a_notify: assert property (p_notify) else $error("notify without cause");

  // wake lags the request by two edges and matches the state shown
  property p_wake; PM_WAKE_REQUEST |-> $past(USER_WAKE, 2) && PME_SUPPORT[PM_STATE];
  endproperty
  a_wake: assert property (p_wake) else $error("wake outside listed state");
  property p_dstate; PM_STATE[0] ^ PM_STATE[1] |-> (PM_STATE == 2'h1 ? D1_SUPPORT : D2_SUPPORT);
  endproperty
  a_dstate: assert property (p_dstate) else $error("unsupported power state");

  c_notify: cover property (HP_CMD_NOTIFY);
  c_wake: cover property (PM_WAKE_REQUEST);
  c_crs: cover property (CRS_TO_SW ##[1:60] CRS_RETRY);
endmodule

// ==== cfg_host.sv ====
// host-side model issuing configuration reads and writes across the link
// assumes requests launch on the falling edge and are taken on the rising one
`timescale 1ns/100ps
module cfg_host (
  input wire logic clk,
  output pcie_cap_pkg::cfg_req_s req,
  input wire pcie_cap_pkg::cfg_rsp_s rsp
);
  // idle lines carry the inverse of the last data, never a stale copy
  initial req = {1'b0, 1'b0, 3'h0, 32'hA5A5_A5A5};

  // one write, held across exactly one taking edge
  task automatic wr(input logic [2:0] idx, input logic [31:0] data);
    @(negedge clk);
    req = {1'b0, 1'b1, idx, data};
    @(negedge clk);
    req = {1'b0, 1'b0, ~idx, ~data};
  endtask

  // one read; the answer stands only in the cycle after the taking edge
  task automatic rd(input logic [2:0] idx, output logic [31:0] data, output logic valid);
    @(negedge clk);
    req = {1'b1, 1'b0, idx, ~req.data};
    @(negedge clk);
    valid = rsp.valid;
    data = rsp.data;
    req = {1'b0, 1'b0, ~idx, ~req.data};
  endtask
endmodule

// ==== pcie_capability_fields_bench.sv ====
// self-checking bench for the capability field bank
// assumes the host model and the checker are compiled alongside
`timescale 1ns/100ps
module pcie_capability_fields_bench;
  localparam logic [7:0] PWR_VAL = 8'h5A;
  localparam logic [12:0] SLOT_NUM = 13'h0123;
  localparam logic [28:0] TBL_OFF = 29'h0000_0040;
  localparam logic [28:0] PBA_OFF = 29'h0000_0080;
  localparam logic [4:0] PME_SUP = 5'h09;
  localparam bit ON = 1'b1;
  // slot flags set: button, power controller, surprise, capable, interlock
  localparam logic [31:0] SLOT_CAP = {SLOT_NUM, 2'b01, 2'h2, PWR_VAL, 7'b1100011};
  localparam logic [31:0] PM_CAP = {PME_SUP, 1'b0, 1'b1, 3'h0, 1'b1, 2'h0,
    pcie_cap_pkg::PM_VERSION, pcie_cap_pkg::PM_NEXT_PTR, pcie_cap_pkg::PM_CAP_ID};
  typedef struct packed {logic wr; logic [2:0] idx; logic [31:0] data; logic [31:0] exp;} row_s;
  // table bir 1 is the upper half of a pair, so it reads back as 0
  row_s rows [15] = '{
    '{1'b0, 3'h0, 32'h0, 32'h0000_0001}, '{1'b0, 3'h1, 32'h0, SLOT_CAP},
    '{1'b0, 3'h2, 32'h0, 32'h0}, '{1'b0, 3'h3, 32'h0, {TBL_OFF, 3'h0}},
    '{1'b0, 3'h4, 32'h0, {PBA_OFF, 3'h0}}, '{1'b0, 3'h5, 32'h0, PM_CAP},
    '{1'b0, 3'h6, 32'h0, 32'h0000_0008}, '{1'b0, 3'h7, 32'h0, 32'h0},
    '{1'b1, 3'h1, 32'hFFFF_FFFF, SLOT_CAP}, '{1'b1, 3'h3, 32'hFFFF_FFFF, {TBL_OFF, 3'h0}},
    '{1'b1, 3'h4, 32'hFFFF_FFFF, {PBA_OFF, 3'h0}}, '{1'b1, 3'h5, 32'hFFFF_FFFF, PM_CAP},
    '{1'b1, 3'h7, 32'hFFFF_FFFF, 32'h0}, '{1'b1, 3'h0, 32'hFFFF_FFFF, 32'h0001_0001},
    '{1'b1, 3'h6, 32'h0000_0100, 32'h0000_0108}};
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic ce = 1'b1;
  logic pres_wr = 1'b0;
  logic pres = 1'b0;
  logic cmd_done = 1'b0;
  logic cpl_crs = 1'b0;
  logic wake_in = 1'b0;
  logic notify, crs_sw, crs_retry, wake, msix, slot_en;
  logic [1:0] pm_state;
  pcie_cap_pkg::cfg_req_s req;
  pcie_cap_pkg::cfg_rsp_s rsp;
  int num_errors = 0;
  int n_compared = 0;
  int cycles = 0;

  pcie_capability_fields #(.SLOT_IMPLEMENTED(ON), .CRS_SW_VIS(ON), .ATTN_BUTTON(ON),
    .PWR_CTRL(ON), .HP_SURPRISE(ON), .HP_CAPABLE(ON), .EM_INTERLOCK(ON),
    .SLOT_PWR_VALUE(PWR_VAL), .SLOT_PWR_SCALE(2'h2), .PHYS_SLOT_NUM(SLOT_NUM),
    .MSIX_ENABLE(ON), .MEM_BAR_MASK(6'h03), .BAR64_UPPER_MASK(6'h02),
    .MSIX_TBL_OFFSET(TBL_OFF), .MSIX_TBL_BIR(3'h1), .MSIX_PBA_OFFSET(PBA_OFF),
    .DEV_SPEC_INIT(ON), .D1_SUPPORT(ON), .PME_SUPPORT(PME_SUP)) i_dut (
    .CLK(clk), .ARST_N(arst_n), .CE(ce), .CFG_REQ(req), .CFG_RSP(rsp),
    .MGMT_PRESENCE_WR(pres_wr), .MGMT_PRESENCE(pres), .HP_CMD_DONE(cmd_done),
    .HP_CMD_NOTIFY(notify), .CPL_CRS(cpl_crs), .CRS_TO_SW(crs_sw), .CRS_RETRY(crs_retry),
    .USER_WAKE(wake_in), .PM_WAKE_REQUEST(wake), .PM_STATE(pm_state),
    .MSIX_PRESENT(msix), .SLOT_ENABLED(slot_en));
  cfg_host i_host (.clk(clk), .req(req), .rsp(rsp));

  initial forever #5 clk = ~clk;

  // hang guard: the whole sequence needs about a hundred cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      num_errors++;
      report_and_stop();
    end
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic rd_chk(input string nm, input logic [2:0] idx, input logic [31:0] exp);
    logic [31:0] d;
    logic v;
    i_host.rd(idx, d, v);
    chk({nm, " valid"}, v, 32'h1);
    chk(nm, d, exp);
  endtask

  task automatic report_and_stop();
    $display("compared %0d, mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  initial begin
    repeat (10) @(negedge clk);
    chk("slot_en in reset", slot_en, 32'h0);
    chk("rsp in reset", 32'(|rsp), 32'h0);
    arst_n = 1'b1;
    repeat (4) @(negedge clk);
    chk("slot_en", slot_en, 32'h1);
    chk("msix", msix, 32'h1);
    $display("test reset done");
    for (int i = 0; i < 15; i++) begin
      if (rows[i].wr) i_host.wr(rows[i].idx, rows[i].data);
      rd_chk($sformatf("row %0d", i), rows[i].idx, rows[i].exp);
    end
    $display("test table done");
    // power states: d2 unsupported, d3hot back to d0 keeps context
    i_host.wr(3'h6, 32'h0000_0101);
    @(negedge clk);
    chk("state d1", pm_state, 32'h1);
    i_host.wr(3'h6, 32'h0000_0102);
    @(negedge clk);
    chk("state d2 refused", pm_state, 32'h1);
    i_host.wr(3'h6, 32'h0000_0103);
    i_host.wr(3'h6, 32'h0000_0100);
    @(negedge clk);
    chk("state d0", pm_state, 32'h0);
    rd_chk("root kept", 3'h0, 32'h0001_0001);
    $display("test power state done");
    // wake only in listed states, status sticks until cleared
    wake_in = 1'b1;
    repeat (3) @(negedge clk);
    chk("wake d0", wake, 32'h1);
    i_host.wr(3'h6, 32'h0000_0101);
    repeat (3) @(negedge clk);
    chk("wake d1", wake, 32'h0);
    wake_in = 1'b0;
    rd_chk("pme status", 3'h6, 32'h0000_8109);
    i_host.wr(3'h6, 32'h0000_8100);
    rd_chk("pme cleared", 3'h6, 32'h0000_0108);
    $display("test wake done");
    // presence written by the user side
    pres = 1'b1;
    pres_wr = 1'b1;
    @(negedge clk);
    pres_wr = 1'b0;
    rd_chk("presence", 3'h2, 32'h0040_0000);
    // command completion notify with interrupt enable set, then cleared
    i_host.wr(3'h2, 32'h0000_0010);
    cmd_done = 1'b1;
    @(negedge clk);
    chk("notify on", notify, 32'h1);
    cmd_done = 1'b0;
    rd_chk("cmd done", 3'h2, 32'h0050_0010);
    i_host.wr(3'h2, 32'h0010_0000);
    rd_chk("cmd cleared", 3'h2, 32'h0040_0000);
    cmd_done = 1'b1;
    @(negedge clk);
    chk("notify off", notify, 32'h0);
    cmd_done = 1'b0;
    $display("test hot plug done");
    // crs to software while enabled, retried once enable is cleared
    cpl_crs = 1'b1;
    @(negedge clk);
    chk("crs sw", {crs_sw, crs_retry}, 32'h2);
    cpl_crs = 1'b0;
    i_host.wr(3'h0, 32'h0000_0000);
    cpl_crs = 1'b1;
    @(negedge clk);
    chk("crs retry", {crs_sw, crs_retry}, 32'h1);
    cpl_crs = 1'b0;
    $display("test crs done");
    report_and_stop();
  end
endmodule

bind pcie_capability_fields pcie_capability_fields_asserts #(
  .PORT_IS_ROOT(PORT_IS_ROOT), .SLOT_IMPLEMENTED(SLOT_IMPLEMENTED), .CRS_SW_VIS(CRS_SW_VIS),
  .NO_CMD_CPL(NO_CMD_CPL), .MSIX_ENABLE(MSIX_ENABLE), .MEM_BAR_MASK(MEM_BAR_MASK),
  .D1_SUPPORT(D1_SUPPORT), .D2_SUPPORT(D2_SUPPORT), .PME_SUPPORT(PME_SUPPORT)) i_chk (
  .CLK(CLK), .ARST_N(ARST_N), .CE(CE), .CFG_REQ(CFG_REQ), .CFG_RSP(CFG_RSP),
  .MGMT_PRESENCE_WR(MGMT_PRESENCE_WR), .MGMT_PRESENCE(MGMT_PRESENCE),
  .HP_CMD_DONE(HP_CMD_DONE), .HP_CMD_NOTIFY(HP_CMD_NOTIFY), .CPL_CRS(CPL_CRS),
  .CRS_TO_SW(CRS_TO_SW), .CRS_RETRY(CRS_RETRY), .USER_WAKE(USER_WAKE),
  .PM_WAKE_REQUEST(PM_WAKE_REQUEST), .PM_STATE(PM_STATE), .MSIX_PRESENT(MSIX_PRESENT),
  .SLOT_ENABLED(SLOT_ENABLED));
